// ### eeprom_regs.vh
// Constants for the serial EEPROM write-control block
`ifndef EEPROM_REGS_VH
`define EEPROM_REGS_VH
`define ADDR_W           9
`define DATA_W           16
`define DEPTH            512
`define OP_READ          2'h0_2
`define OP_WRITE         2'h0_1
`define OP_ERASE         2'h0_3
`define OP_SPECIAL       2'h0_0
`define SUB_ENABLE       2'h0_3
`define SUB_DISABLE      2'h0_0
`define SUB_WRITE_ALL    2'h0_1
`define SUB_ERASE_ALL    2'h0_2
`define ERASED_WORD      16'hFFFF
`define CLK_MHZ          50
`define PROG_TIME_US     10000
`define PROG_CYCLES      (`PROG_TIME_US * `CLK_MHZ)
`define HDR_BITS         11
`endif

// ### sync_bit.v
// Two-flop synchroniser for one asynchronous pin
`timescale 1ns/1ps
module sync_bit (
   input  wire mclk,
   input  wire reset,
   input  wire asyncIn,
   output reg  syncOut
);
   reg stage1;   // First stage, read only by the second
   // Metastability guard
   always @(posedge mclk) begin
      if (reset) begin
         stage1  <= 1'b0;
         syncOut <= 1'b0;
      end else begin
         stage1  <= asyncIn;
         syncOut <= stage1;
      end
   end
endmodule

// ### word_mem.v
// Word array of the EEPROM with registered read data
`timescale 1ns/1ps
`include "eeprom_regs.vh"
module word_mem (
   input  wire                 mclk,
   input  wire                 wrEn,
   input  wire [`ADDR_W-1:0]   wrAddr,
   input  wire [`DATA_W-1:0]   wrData,
   input  wire [`ADDR_W-1:0]   rdAddr,
   output reg  [`DATA_W-1:0]   rdData
);
   reg [`DATA_W-1:0] cells [0:`DEPTH-1];   // Array contents
   integer i;
   // Delivery state is all ones
   initial begin
      for (i = 0; i < `DEPTH; i = i + 1) begin
         cells[i] = `ERASED_WORD;
      end
   end
   // One write port, one registered read port
   always @(posedge mclk) begin
      if (wrEn) begin
         cells[wrAddr] <= wrData;
      end
      rdData <= cells[rdAddr];
   end
endmodule

// ### microwire_eeprom_write_control.v
// Serial EEPROM write-side command logic: decode, program timer, verify status
// Notes on behaviour
// [RULE_01] Programming starts only at CS fall after enough clocks
// [RULE_02] Every write finishes within maximum write time
// [RULE_03] CS high after write: DO low busy, high ready
// [RULE_04] Busy check repeatable, held or pulsed CS
// [RULE_05] SK and DI ignored while programming
// [RULE_06] Host starts instruction only with DO high/Z
// [RULE_07] Start bit releases driven-high DO at once
// [RULE_08] Host holds DI low during busy check
// [RULE_09] Write keeps last sixteen data bits shifted
// [RULE_10] Write stores directly, starts at CS fall
// [RULE_11] Erase sets addressed word to all ones
// [RULE_12] Write-all programs last data word everywhere
// [RULE_13] Erase-all sets every word to ones
// [RULE_14] Enable command enters program-enabled mode
// [RULE_15] Disable command blocks all array changes
// [RULE_16] Power-up/low supply cancels write, disables programming
// [RULE_17] Host re-enables after supply recovery
// [RULE_18] Host keeps programming disabled when idle
// [RULE_19] Start bit is DI high at SK rise
// [RULE_20] Only after write, CS high drives status
// [RULE_21] No array write while CS stays low
// [RULE_22] Start, opcode, address, data on SK rise
// [RULE_23] CS low means standby, inputs ignored
// [RULE_24] Leading low-DI clocks are dummy, ignored
// [RULE_25] Host drops CS between instructions
// [RULE_26] Opcodes 01 write, 11 erase, 00 specials
// [RULE_27] Busy counter configurable, never beyond limit
`timescale 1ns/1ps
`include "eeprom_regs.vh"
module microwire_eeprom_write_control #(
   parameter PROG_CYCLES = `PROG_CYCLES   // Programming interval in mclk cycles
) (
   input  wire                 mclk,
   input  wire                 reset,
   input  wire                 lowSupply,
   input  wire                 chipSelect,
   input  wire                 serialClock,
   input  wire                 dataIn,
   output reg                  dataOut,
   output reg                  dataOutEn,
   output wire                 programEnabled,
   output wire                 programBusy,
   input  wire [`ADDR_W-1:0]   peekAddr,
   output wire [`DATA_W-1:0]   peekData
);
   // Pins are sampled by mclk, so SK high and low phases must each last
   // a few mclk periods; shorter pulses can slip between samples
   // Command phases
   localparam PH_IDLE   = 2'd0;   // Waiting for start bit
   localparam PH_HEADER = 2'd1;   // Opcode and address
   localparam PH_DATA   = 2'd2;   // Data or surplus bits
   // Programming machine states
   // A single write and a whole-array sweep time the interval in the same counter
   localparam PG_IDLE   = 2'd0;
   localparam PG_RUN    = 2'd1;   // Busy counting
   localparam PG_ALL    = 2'd2;   // Sweeping every word
   // Clamp keeps a short simulation value legal and a large one inside the write time;
   // zero would end the interval before it began, so one cycle is the floor
   localparam [31:0] PROG_LIMIT = (PROG_CYCLES < 1) ? 32'd1 :
                                  ((PROG_CYCLES > `PROG_CYCLES) ? `PROG_CYCLES : PROG_CYCLES);

   wire csSync;          // Synchronised CS
   wire skSync;          // Synchronised SK
   wire diSync;          // Synchronised DI
   wire lowSync;         // Synchronised low-supply detector
   reg  csLast;          // Previous CS for edges
   reg  skLast;          // Previous SK for edges
   reg  [1:0]  phase;    // Command phase
   reg  [3:0]  hdrCount; // Header bits taken
   reg  [10:0] header;   // Opcode plus address
   reg  [15:0] shiftData;// Data shift register
   reg  [4:0]  dataCount;// Data bits taken, saturating
   reg  enabled;         // Program-enabled mode
   reg  [1:0]  pgState;  // Programming state
   reg  [31:0] busyCount;// Busy timer
   reg  [`ADDR_W-1:0] sweepAddr;  // Address during sweep or single write
   reg  [`DATA_W-1:0] pgData;     // Word being programmed
   reg  pgAll;           // Whole-array operation
   reg  pgDone;          // Sweep finished
   reg  statusArmed;     // A write ran since last start bit
   reg  memWr;           // Array write strobe
   reg  [`ADDR_W-1:0] memAddr;    // Address latched with the strobe

   // Edges come from synchronised copies, so they lag the pins by about three cycles;
   // DI takes the same path and stays lined up with the SK edge that samples it
   wire skRise = skSync & ~skLast;        // SK rising edge
   wire csFall = ~csSync & csLast;        // End of an instruction
   wire busy   = (pgState != PG_IDLE);    // Programming in progress
   // Header fields: opcode first, then nine address bits
   wire [1:0] opcode  = header[10:9];
   wire [1:0] subOp   = header[8:7];      // Top address bits pick the special commands
   wire [`ADDR_W-1:0] addrField = header[8:0];
   // Array-changing commands, judged at CS fall
   wire fullData  = (dataCount == 5'd16); // Sixteen or more data bits arrived
   wire wordWrite = (opcode == `OP_WRITE) && fullData;
   wire wordErase = (opcode == `OP_ERASE);
   wire allWrite  = (opcode == `OP_SPECIAL) && (subOp == `SUB_WRITE_ALL) && fullData;
   wire allErase  = (opcode == `OP_SPECIAL) && (subOp == `SUB_ERASE_ALL);
   // Start strobe for the status logic; it repeats the timer's own start conditions, so they cannot disagree
   wire writeGo   = (pgState == PG_IDLE) && csFall && (phase == PH_DATA) && enabled &&
                    (wordWrite || wordErase || allWrite || allErase);

   // Mode and busy are visible to the system and to the checker
   assign programEnabled = enabled;
   assign programBusy    = busy;

   // Every pin passes two flops before logic reads it; the supply detector is
   // asynchronous as well, so it takes the same path
   sync_bit uSyncCs  (.mclk(mclk), .reset(reset), .asyncIn(chipSelect),  .syncOut(csSync));
   sync_bit uSyncSk  (.mclk(mclk), .reset(reset), .asyncIn(serialClock), .syncOut(skSync));
   sync_bit uSyncDi  (.mclk(mclk), .reset(reset), .asyncIn(dataIn),      .syncOut(diSync));
   sync_bit uSyncLow (.mclk(mclk), .reset(reset), .asyncIn(lowSupply),   .syncOut(lowSync));

   // Write address comes from a register loaded with the strobe: the sweep
   // counter has already moved on when the registered strobe reaches the array
   word_mem uMem (
      .mclk   (mclk),
      .wrEn   (memWr),
      .wrAddr (memAddr),
      .wrData (pgData),
      .rdAddr (peekAddr),
      .rdData (peekData)
   );

   // Edge history
   // Reset value matches the idle pin level, so no false edge follows reset
   always @(posedge mclk) begin
      if (reset) begin
         csLast <= 1'b0;
         skLast <= 1'b0;
      end else begin
         csLast <= csSync;
         skLast <= skSync;
      end
   end

   // Serial command shifter
   // Busy or deselected: the frame is dropped and must restart with a start bit
   always @(posedge mclk) begin
      if (reset || lowSync) begin
         // Brownout throws away any half-received instruction
         phase     <= PH_IDLE;
         hdrCount  <= 4'd0;
         header    <= 11'd0;
         shiftData <= 16'h0000;
         dataCount <= 5'd0;
      end else if (!csSync || busy) begin
         // Standby or programming: inputs ignored, command dropped
         phase     <= PH_IDLE;   // RULE_23
         hdrCount  <= 4'd0;      // RULE_05
         dataCount <= 5'd0;
      end else if (skRise) begin
         case (phase)
            PH_IDLE: begin
               // Low DI clocks are dummies
               // A host may pad frames with these to fit its own word length
               if (diSync) begin                 // RULE_19 RULE_24
                  phase <= PH_HEADER;
               end
            end
            PH_HEADER: begin
               // Two opcode bits, then nine address bits, MSB first
               header   <= {header[9:0], diSync};   // RULE_22
               hdrCount <= hdrCount + 4'd1;
               // Eleventh bit completes the header; anything later is data
               if (hdrCount == 4'd10) begin
                  phase <= PH_DATA;
               end
            end
            PH_DATA: begin
               // Surplus bits keep shifting; last sixteen win
               shiftData <= {shiftData[14:0], diSync};   // RULE_09
               // Count saturates: it only tells whether a whole word came
               if (dataCount != 5'd16) begin
                  dataCount <= dataCount + 5'd1;
               end
            end
            // Unused code: fall back to waiting for a start bit
            default: phase <= PH_IDLE;
         endcase
      end
   end

   // Mode, programming start, busy timer and array sweep
   // Strobe defaults low so each array write lasts exactly one cycle
   always @(posedge mclk) begin
      memWr <= 1'b0;
      if (reset || lowSync) begin
         // Power-up or brownout: cancel and lock
         enabled   <= 1'b0;          // RULE_16
         pgState   <= PG_IDLE;
         busyCount <= 32'd0;
         sweepAddr <= {`ADDR_W{1'b0}};
         pgData    <= `ERASED_WORD;
         pgAll     <= 1'b0;
         pgDone    <= 1'b0;
         memAddr   <= {`ADDR_W{1'b0}};
      end else begin
         case (pgState)
            PG_IDLE: begin
               // Decisions only at CS fall with full header
               // Nothing happens while CS stays high or low; only its fall commits
               if (csFall && phase == PH_DATA) begin   // RULE_01 RULE_21
                  // Mode commands need no data and never start the timer
                  if (opcode == `OP_SPECIAL && subOp == `SUB_ENABLE) begin
                     enabled <= 1'b1;                    // RULE_14 RULE_26
                  end else if (opcode == `OP_SPECIAL && subOp == `SUB_DISABLE) begin
                     enabled <= 1'b0;                    // RULE_15
                  end else if (enabled) begin
                     // Disabled mode drops write-class commands without a trace
                     busyCount <= 32'd0;
                     pgDone    <= 1'b0;
                     // Short data field: write refused rather than storing a partial word
                     if (opcode == `OP_WRITE && dataCount == 5'd16) begin
                        pgState   <= PG_RUN;             // RULE_10
                        pgAll     <= 1'b0;
                        sweepAddr <= addrField;
                        pgData    <= shiftData;
                     end else if (opcode == `OP_ERASE) begin
                        // No data field: whatever was shifted is ignored
                        pgState   <= PG_RUN;             // RULE_11
                        pgAll     <= 1'b0;
                        sweepAddr <= addrField;
                        pgData    <= `ERASED_WORD;
                     end else if (opcode == `OP_SPECIAL && subOp == `SUB_WRITE_ALL
                                  && dataCount == 5'd16) begin
                        // Address bits below the selector are ignored
                        pgState   <= PG_ALL;             // RULE_12
                        pgAll     <= 1'b1;
                        sweepAddr <= {`ADDR_W{1'b0}};
                        pgData    <= shiftData;
                     end else if (opcode == `OP_SPECIAL && subOp == `SUB_ERASE_ALL) begin
                        // Sweep starts at word zero
                        pgState   <= PG_ALL;             // RULE_13
                        pgAll     <= 1'b1;
                        sweepAddr <= {`ADDR_W{1'b0}};
                        pgData    <= `ERASED_WORD;
                     end
                  end
               end
            end
            PG_ALL: begin
               // One word per cycle; inside the interval only when PROG_LIMIT is 512 or more
               if (!pgDone) begin
                  memWr   <= 1'b1;
                  memAddr <= sweepAddr;
                  if (sweepAddr == `DEPTH - 1) begin
                     // Last word: hold the address and stop the sweep
                     pgDone <= 1'b1;
                  end else begin
                     sweepAddr <= sweepAddr + 1'b1;
                  end
               end
               // Timer runs beside the sweep: busy lasts the longer of the two
               busyCount <= busyCount + 32'd1;
               if (busyCount >= PROG_LIMIT - 32'd1 && pgDone) begin   // RULE_02 RULE_27
                  pgState <= PG_IDLE;
               end
            end
            PG_RUN: begin
               // Word committed at the end of the interval
               // A brownout before then leaves the old word untouched
               busyCount <= busyCount + 32'd1;
               if (busyCount >= PROG_LIMIT - 32'd1) begin   // RULE_02 RULE_27
                  memWr   <= 1'b1;
                  memAddr <= sweepAddr;
                  pgState <= PG_IDLE;
               end
            end
            default: pgState <= PG_IDLE;
         endcase
      end
   end

   // Status output: armed by a write, dropped by a start bit
   always @(posedge mclk) begin
      if (reset || lowSync) begin
         // Power-up: DO released, no status pending
         statusArmed <= 1'b0;
         dataOut     <= 1'b0;
         dataOutEn   <= 1'b0;
      end else begin
         // Armed only by a command that really started; a refused one leaves DO off
         if (writeGo) begin
            statusArmed <= 1'b1;                      // RULE_20
         // Start bit ends the status phase; during programming SK is ignored
         end else if (!busy && csSync && skRise && diSync) begin
            statusArmed <= 1'b0;                      // RULE_07
         end
         // Drive only while selected after a write
         // DO shows the state of the cycle before: one cycle late at the end of busy
         // Start bit releases DO in the same cycle the shifter takes it
         if (csSync && statusArmed && !(skRise && diSync && !busy)) begin   // RULE_03 RULE_04
            dataOutEn <= 1'b1;
            dataOut   <= ~busy;
         end else begin
            // Released: high impedance, value parked low
            dataOutEn <= 1'b0;
            dataOut   <= 1'b0;
         end
      end
   end
endmodule

// ### microwire_eeprom_write_control_checker.sv
// Assertion checker for the serial EEPROM write-control block
`timescale 1ns/1ps
`include "eeprom_regs.vh"
module microwire_eeprom_write_control_checker #(
   parameter PROG_CYCLES = `PROG_CYCLES   // Programming interval in mclk cycles
) (
   input wire                 mclk,
   input wire                 reset,
   input wire                 lowSupply,
   input wire                 chipSelect,
   input wire                 serialClock,
   input wire                 dataIn,
   input wire                 dataOut,
   input wire                 dataOutEn,
   input wire                 programEnabled,
   input wire                 programBusy,
   input wire [`ADDR_W-1:0]   peekAddr,
   input wire [`DATA_W-1:0]   peekData
);
   // Whole-array ops may stretch to 513 cycles, plus a little slack
   localparam int LIM = (PROG_CYCLES > 513 ? PROG_CYCLES : 513) + 4;
   int busyLen;   // Length of the current busy stretch
   // Counts busy cycles so the bound needs no long repetition
   always @(posedge mclk) begin
      if (reset || !programBusy) busyLen <= 0;
      else busyLen <= busyLen + 1;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   property p_startAtFall; $rose(programBusy) |-> !chipSelect && !$past(chipSelect, 2); endproperty
   a_startAtFall: assert property (p_startAtFall) else $error("busy began with CS high");
   property p_busyBound; busyLen <= LIM; endproperty
   a_busyBound: assert property (p_busyBound) else $error("programming ran too long");
   property p_busyLow; dataOutEn && programBusy |-> !dataOut; endproperty
   a_busyLow: assert property (p_busyLow) else $error("DO high while busy");
   property p_ready; $fell(programBusy) && dataOutEn |-> ##[0:2] dataOut; endproperty
   a_ready: assert property (p_ready) else $error("DO not high after programming");
   property p_standby; $fell(chipSelect) |-> ##[0:5] !dataOutEn; endproperty
   a_standby: assert property (p_standby) else $error("DO kept driving with CS low");
   property p_driveCs; $rose(dataOutEn) |-> chipSelect; endproperty
   a_driveCs: assert property (p_driveCs) else $error("DO driven without CS");
   property p_startFree;
      $rose(serialClock) && dataIn && chipSelect && dataOutEn && !programBusy |-> ##[1:6] !dataOutEn;
   endproperty
   a_startFree: assert property (p_startFree) else $error("start bit did not free DO");
   property p_noLocked; $rose(programBusy) |-> programEnabled; endproperty
   a_noLocked: assert property (p_noLocked) else $error("programming while disabled");
   property p_lowSup; $rose(lowSupply) |-> ##[1:6] !programEnabled && !programBusy; endproperty
   a_lowSup: assert property (p_lowSup) else $error("low supply did not cancel");
endmodule
bind microwire_eeprom_write_control microwire_eeprom_write_control_checker #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
   .mclk(mclk), .reset(reset), .lowSupply(lowSupply), .chipSelect(chipSelect), .serialClock(serialClock),
   .dataIn(dataIn), .dataOut(dataOut), .dataOutEn(dataOutEn), .programEnabled(programEnabled),
   .programBusy(programBusy), .peekAddr(peekAddr), .peekData(peekData));

// ### microwire_host.sv
// Serial bus master model driving chip select, serial clock and data
`timescale 1ns/1ps
module microwire_host (
   input  wire  mclk,
   output logic chipSelect,
   output logic serialClock,
   output logic dataIn
);
   // Pins idle low; SK stands still outside frames, except where t_disable clocks it with CS low
   initial begin
      chipSelect = 0;
      serialClock = 0;
      dataIn = 0;
   end
   // Select the device
   task automatic sel();
      @(negedge mclk) chipSelect = 1;
      repeat (8) @(negedge mclk);
   endtask
   // One bit per 160 ns SK period, DI steady across the rise
   task automatic shift(input logic b);
      dataIn = b;
      repeat (4) @(negedge mclk);
      serialClock = 1;
      repeat (4) @(negedge mclk);
      serialClock = 0;
   endtask
   // End the instruction; DI parks low for any busy check
   task automatic close();
      dataIn = 0;
      repeat (4) @(negedge mclk);
      chipSelect = 0;
      repeat (8) @(negedge mclk);
   endtask
endmodule

// ### microwire_eeprom_write_control_tb.sv
// Testbench for the serial EEPROM write-control block
`timescale 1ns/1ps
module microwire_eeprom_write_control_tb;
   localparam logic [11:0] EN = 12'h980;   // Enable frame
   logic mclk, reset, lowSupply, cs, sk, di, dataOut, dataOutEn, programEnabled, programBusy;
   logic [8:0]  peekAddr;
   logic [15:0] peekData;
   int          n_fail, n_tests;
   microwire_host HOST (.mclk(mclk), .chipSelect(cs), .serialClock(sk), .dataIn(di));
   microwire_eeprom_write_control #(.PROG_CYCLES(200)) DUT (.mclk(mclk), .reset(reset), .lowSupply(lowSupply),
      .chipSelect(cs), .serialClock(sk), .dataIn(di), .dataOut(dataOut), .dataOutEn(dataOutEn),
      .programEnabled(programEnabled), .programBusy(programBusy), .peekAddr(peekAddr), .peekData(peekData));
   initial begin
      mclk = 0;
      forever #10 mclk = ~mclk;
   end
   task automatic close_out();
      if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic send(input logic [63:0] v, input int n);
      HOST.sel();
      for (int i = n - 1; i >= 0; i--) HOST.shift(v[i]);
   endtask
   task automatic cmd(input logic [63:0] v, input int n);
      send(v, n);
      HOST.close();
   endtask
   // Busy check: DO low, then high, then a start bit frees it
   task automatic verify();
      HOST.sel();
      chk("doEn", 1, dataOutEn);
      chk("doBusy", 0, dataOut);
      for (int k = 0; k < 1200 && dataOut !== 1'b1; k++) @(negedge mclk);
      chk("doReady", 1, dataOut);
      HOST.shift(1);
      repeat (4) @(negedge mclk);
      chk("doFree", 0, dataOutEn);
      HOST.close();
   endtask
   task automatic peek(input logic [8:0] a, input logic [15:0] e);
      peekAddr = a;
      repeat (2) @(negedge mclk);
      chk("peekData", e, peekData);
   endtask
   task automatic t_locked();
      chk("enabled", 0, programEnabled);
      cmd({1'b1, 2'b01, 9'h005, 16'h0000}, 28);
      repeat (300) @(negedge mclk);
      peek(9'h005, 16'hFFFF);
   endtask
   task automatic t_enable();
      cmd(EN, 12);
      chk("enabled", 1, programEnabled);
      cmd({1'b1, 2'b10, 9'h005}, 12);
      chk("busy", 0, programBusy);
      HOST.sel();
      chk("doEn", 0, dataOutEn);
      HOST.close();
   endtask
   task automatic t_write();
      send({1'b1, 2'b01, 9'h005, 20'hA_1234}, 35);
      chk("busy", 0, programBusy);
      HOST.close();
      chk("busy", 1, programBusy);
      verify();
      peek(9'h005, 16'h1234);
      cmd({1'b1, 2'b11, 9'h005}, 12);
      verify();
      peek(9'h005, 16'hFFFF);
   endtask
   task automatic t_whole();
      cmd({1'b1, 2'b00, 9'h080, 20'h9_5A5A}, 32);
      verify();
      peek(9'h000, 16'h5A5A);
      peek(9'h1FF, 16'h5A5A);
      cmd({1'b1, 2'b00, 9'h100}, 12);
      verify();
      peek(9'h000, 16'hFFFF);
      peek(9'h12C, 16'hFFFF);
   endtask
   task automatic t_disable();
      cmd({1'b1, 2'b00, 9'h000}, 12);
      chk("enabled", 0, programEnabled);
      for (int i = 11; i >= 0; i--) HOST.shift(EN[i]);
      chk("enabled", 0, programEnabled);
      cmd({1'b1, 2'b01, 9'h007, 16'h0000}, 28);
      chk("busy", 0, programBusy);
      peek(9'h007, 16'hFFFF);
   endtask
   task automatic t_supply();
      cmd(EN, 12);
      cmd({1'b1, 2'b01, 9'h009, 16'h0000}, 28);
      lowSupply = 1;
      repeat (8) @(negedge mclk);
      chk("enabled", 0, programEnabled);
      chk("busy", 0, programBusy);
      peek(9'h009, 16'hFFFF);
      lowSupply = 0;
      repeat (4) @(negedge mclk);
      cmd({1'b1, 2'b01, 9'h00A, 16'h0000}, 28);
      repeat (300) @(negedge mclk);
      peek(9'h00A, 16'hFFFF);
   endtask
   // Watchdog well beyond the expected run of about 4500 cycles
   initial begin
      repeat (60000) @(posedge mclk);
      n_fail++;
      close_out();
   end
   initial begin
      reset = 1;
      lowSupply = 0;
      peekAddr = 0;
      n_fail = 0;
      n_tests = 0;
      repeat (3) @(negedge mclk);
      reset = 0;
      repeat (4) @(negedge mclk);
      t_locked();
      t_enable();
      t_write();
      t_whole();
      t_disable();
      t_supply();
      close_out();
   end
endmodule
